// ==== core/rx_sync_pkg.sv ====
// constants and carrier types for the receive word sync and run-length block
// assumes one clock: the low-speed recovered clock of the channel
package rx_sync_pkg;

	localparam int WORD_W       = 10;
	localparam int PAIR_W       = 20;
	localparam int FIFO_DEPTH   = 8;
	localparam int ERR_W        = 7;
	localparam int GOOD_W       = 9;
	localparam int ACQ_W        = 8;
	localparam int RLV_SEL_W    = 5;
	localparam int RUN_W        = 8;
	localparam int HOLD_W       = 2;

	localparam logic [RUN_W-1:0]  RLV_STEP_8B  = 8'h04;
	localparam logic [RUN_W-1:0]  RLV_STEP_10B = 8'h05;
	localparam logic [HOLD_W-1:0] RLV_HOLD     = 2'h2;
	localparam logic [WORD_W-1:0] MASK_10B     = 10'h3FF;
	localparam logic [WORD_W-1:0] MASK_8B      = 10'h0FF;

	typedef enum logic [2:0] {
		ST_IDLE = 3'h1,
		ST_ACQ  = 3'h2,
		ST_SYNC = 3'h4
	} sync_state_t;

	// err_limit 1..64, good_run 1..256 (9 bits), rlv_sel n gives (n+1) steps
	typedef struct packed {
		logic [WORD_W-1:0]    pattern;
		logic [ERR_W-1:0]     err_limit;
		logic [GOOD_W-1:0]    good_run;
		logic [ACQ_W-1:0]     acq_needed;
		logic                 auto_sync;
		logic                 width_10;
		logic                 byte_deser;
		logic [RLV_SEL_W-1:0] rlv_sel;
	} rx_cfg_t;

	typedef struct packed {
		logic [WORD_W-1:0] word;
		logic              code_err;
	} rx_word_t;

endpackage

// ==== core/pair_fifo.sv ====
// synchronous fifo of parameter width and depth, valid/ready on both sides
// assumes DEPTH is a power of two
`timescale 1ns/100ps
module pair_fifo #(
	parameter int W     = 20,
	parameter int DEPTH = 8
) (
	input  wire logic         clk,
	input  wire logic         resetn,
	input  wire logic         in_valid,
	input  wire logic [W-1:0] in_data,
	output logic              in_ready,
	output logic              out_valid,
	output logic [W-1:0]      out_data,
	input  wire logic         out_ready
);
	localparam int AW = $clog2(DEPTH);

	typedef struct packed {
		logic [AW-1:0] wr_ptr;
		logic [AW-1:0] rd_ptr;
		logic [AW:0]   count;
	} fifo_q_t;

	fifo_q_t        s_q;
	fifo_q_t        s_d;
	logic [W-1:0]   mem_q [DEPTH];
	logic           push;
	logic           pop;

	assign in_ready  = (s_q.count != (AW+1)'(DEPTH));
	assign out_valid = (s_q.count != '0);
	assign out_data  = mem_q[s_q.rd_ptr];
	assign push      = in_valid && in_ready;
	assign pop       = out_valid && out_ready;

	always_comb begin
		s_d = s_q;
		if (push) begin
			s_d.wr_ptr = s_q.wr_ptr + 1'b1;
		end
		if (pop) begin
			s_d.rd_ptr = s_q.rd_ptr + 1'b1;
		end
		if (push && !pop) begin
			s_d.count = s_q.count + 1'b1;
		end else if (pop && !push) begin
			s_d.count = s_q.count - 1'b1;
		end
	end

	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			s_q <= '0;
		end else begin
			s_q <= s_d;
		end
	end

	// storage carries no reset, only the pointers and the count do
	always_ff @(posedge clk) begin
		if (push) begin
			mem_q[s_q.wr_ptr] <= in_data;
		end
	end

	fifo_full_c: cover property (@(posedge clk) disable iff (!resetn) !in_ready);

endmodule // pair_fifo

// ==== core/run_length_detect.sv ====
// run-length violation detector over one received word per clock
// assumes bit 0 of each word is the earliest received bit
`timescale 1ns/100ps
module run_length_detect
	import rx_sync_pkg::*;
(
	input  wire logic                 clk,
	input  wire logic                 resetn,
	input  wire logic                 clear,
	input  wire logic                 valid,
	input  wire logic [WORD_W-1:0]    word,
	input  wire logic                 width_10,
	input  wire logic [RLV_SEL_W-1:0] rlv_sel,
	output logic                      rlv
);
	typedef struct packed {
		logic [RUN_W-1:0]  run;
		logic              last_bit;
		logic [HOLD_W-1:0] hold;
		logic              rlv;
	} rlv_q_t;

	rlv_q_t           s_q;
	rlv_q_t           s_d;
	logic             hit;
	logic [RUN_W-1:0] steps;
	logic [RUN_W-1:0] thr;

	assign rlv = s_q.rlv;

	always_comb begin
		s_d   = s_q;
		hit   = 1'b0;
		steps = {3'h0, rlv_sel} + 8'h01;
		thr   = width_10 ? RUN_W'(steps * RLV_STEP_10B) : RUN_W'(steps * RLV_STEP_8B);
		if (clear) begin
			s_d = '0;
		end else begin
			if (valid) begin
				for (int i = 0; i < WORD_W; i++) begin
					if (width_10 || i < 8) begin
						if (word[i] == s_d.last_bit && s_d.run != 8'hFF) begin
							s_d.run = s_d.run + 8'h01;
						end else if (word[i] != s_d.last_bit) begin
							s_d.run = 8'h01;
						end
						s_d.last_bit = word[i];
						if (s_d.run >= thr) begin
							hit = 1'b1;
						end
					end
				end
			end
			// a hit stretches to two clocks so a skewed fabric clock still sees it
			if (hit) begin
				s_d.rlv  = 1'b1;
				s_d.hold = RLV_HOLD - 2'h1;
			end else if (s_q.hold != '0) begin
				s_d.hold = s_q.hold - 2'h1;
			end else begin
				s_d.rlv = 1'b0;
			end
		end
	end

	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			s_q <= '0;
		end else begin
			s_q <= s_d;
		end
	end

	rlv_on_hit_a: assert property (@(posedge clk) disable iff (!resetn)
		hit && !clear |=> rlv)
		else $error("run length hit did not raise violation");
	rlv_two_cycles_a: assert property (@(posedge clk) disable iff (!resetn)
		$rose(rlv) && !clear |=> rlv)
		else $error("violation output shorter than two cycles");
	rlv_seen_c: cover property (@(posedge clk) disable iff (!resetn) $rose(rlv));

endmodule // run_length_detect

// ==== core/rx_word_sync.sv ====
// receive word sync state machine, run-length check and word pairing buffer
// assumes clk is the low-speed recovered clock and all inputs share it
//
// How it works
// - loss-of-sync error count is programmable from 1 to 64
// - each programmed run of 1..256 good groups lowers error count by one
// - after digital reset release in auto mode, scan for pattern or complement
// - raise lock once the programmed number of sync groups is seen
// - lock stays high until the error count reaches its limit, then drops
// - after loss, lock stays low until enough sync groups arrive again
// - count identical consecutive bits and flag a run at the threshold
// - violation flag runs on the recovered clock, held two cycles minimum
// - threshold steps of 4 up to 128, or 5 up to 160 for 10-bit
// - recovered low-speed clock is the clock forwarded to this logic
// - aligner and buffer write side run on the recovered clock
// - downstream stages run on the transmit low-speed clock; the buffer read side here stays on the recovered clock
// - with byte deserialization, buffer writes run at half the word rate
`timescale 1ns/100ps
module rx_word_sync
	import rx_sync_pkg::*;
(
	input  wire logic              clk,
	input  wire logic              resetn,
	input  wire logic              rx_digital_reset,
	input  wire rx_cfg_t           cfg,
	input  wire logic              rx_word_valid,
	input  wire rx_word_t          rx_in,
	output logic                   rx_word_ready,
	output logic                   sync_locked,
	output logic                   rlv,
	output logic                   pcomp_wr_div2,
	output logic                   out_valid,
	output logic [PAIR_W-1:0]      out_data,
	input  wire logic              out_ready
);
	typedef struct packed {
		sync_state_t        st;
		logic [ACQ_W-1:0]   acq_cnt;
		logic [ERR_W-1:0]   err_cnt;
		logic [GOOD_W-1:0]  good_cnt;
		logic               locked;
		logic [WORD_W-1:0]  pair_low;
		logic               pair_phase;
	} sync_q_t;

	sync_q_t            s_q;
	sync_q_t            s_d;
	logic               fifo_in_ready;
	logic               take;
	logic               match;
	logic               push;
	logic [PAIR_W-1:0]  push_data;
	logic [WORD_W-1:0]  mask;

	assign sync_locked   = s_q.locked;
	assign pcomp_wr_div2 = s_q.pair_phase;
	assign rx_word_ready = fifo_in_ready;

	// words are only consumed when the buffer can take them; upstream holds
	assign take = rx_word_valid && fifo_in_ready && !rx_digital_reset;
	assign mask = cfg.width_10 ? MASK_10B : MASK_8B;
	assign match = (((rx_in.word ^ cfg.pattern) & mask) == '0) ||
		(((rx_in.word ^ ~cfg.pattern) & mask) == '0);

	// half-rate write: two words form one entry, low word first
	assign push      = take && (!cfg.byte_deser || s_q.pair_phase);
	assign push_data = cfg.byte_deser ? {rx_in.word, s_q.pair_low} : {10'h000, rx_in.word};

	always_comb begin
		s_d = s_q;
		if (rx_digital_reset) begin
			s_d = '0;
			s_d.st = ST_IDLE;
		end else begin
			if (take && cfg.byte_deser) begin
				s_d.pair_phase = !s_q.pair_phase;
				s_d.pair_low   = rx_in.word;
			end else if (!cfg.byte_deser) begin
				s_d.pair_phase = 1'b0;
			end
			case (s_q.st)
				ST_IDLE: begin
					s_d.locked = 1'b0;
					if (cfg.auto_sync) begin
						s_d.st = ST_ACQ;
					end
				end
				ST_ACQ: begin
					s_d.locked = 1'b0;
					if (!cfg.auto_sync) begin
						s_d.st = ST_IDLE;
						s_d.acq_cnt = '0;
					end else if (take && rx_in.code_err) begin
						s_d.acq_cnt = '0;
					end else if (take && match) begin
						if (s_q.acq_cnt + 8'h01 >= cfg.acq_needed) begin
							s_d.st       = ST_SYNC;
							s_d.locked   = 1'b1;
							s_d.acq_cnt  = '0;
							s_d.err_cnt  = '0;
							s_d.good_cnt = '0;
						end else begin
							s_d.acq_cnt = s_q.acq_cnt + 8'h01;
						end
					end
				end
				ST_SYNC: begin
					if (!cfg.auto_sync) begin
						s_d = '0;
						s_d.st = ST_IDLE;
					end else if (take && rx_in.code_err) begin
						s_d.good_cnt = '0;
						if (s_q.err_cnt + 7'h01 >= cfg.err_limit) begin
							s_d.st      = ST_ACQ;
							s_d.locked  = 1'b0;
							s_d.err_cnt = '0;
						end else begin
							s_d.err_cnt = s_q.err_cnt + 7'h01;
						end
					end else if (take) begin
						// good groups only matter while errors are pending
						if (s_q.good_cnt + 9'h001 >= cfg.good_run) begin
							s_d.good_cnt = '0;
							if (s_q.err_cnt != '0) begin
								s_d.err_cnt = s_q.err_cnt - 7'h01;
							end
						end else begin
							s_d.good_cnt = s_q.good_cnt + 9'h001;
						end
					end
				end
				default: begin
					s_d = '0;
					s_d.st = ST_IDLE;
				end
			endcase
		end
	end

	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			s_q    <= '0;
			s_q.st <= ST_IDLE;
		end else begin
			s_q <= s_d;
		end
	end

	// aligner and buffer write side share the recovered clock
	run_length_detect u_rlv (
		.clk      (clk),
		.resetn   (resetn),
		.clear    (rx_digital_reset),
		.valid    (take),
		.word     (rx_in.word),
		.width_10 (cfg.width_10),
		.rlv_sel  (cfg.rlv_sel),
		.rlv      (rlv)
	);

	// read side is meant for the transmit-clock stages; one clock here
	pair_fifo #(
		.W     (PAIR_W),
		.DEPTH (FIFO_DEPTH)
	) u_fifo (
		.clk       (clk),
		.resetn    (resetn),
		.in_valid  (push),
		.in_data   (push_data),
		.in_ready  (fifo_in_ready),
		.out_valid (out_valid),
		.out_data  (out_data),
		.out_ready (out_ready)
	);

	default clocking cb @(posedge clk); endclocking
	default disable iff (!resetn);

	scan_start_a: assert property (
		s_q.st == ST_IDLE && !rx_digital_reset && cfg.auto_sync |=> s_q.st == ST_ACQ)
		else $error("aligner did not start scanning");

	lock_acquire_a: assert property (
		s_q.st == ST_ACQ && cfg.auto_sync && !rx_digital_reset && take && !rx_in.code_err && match
		&& (s_q.acq_cnt + 8'h01 >= cfg.acq_needed) |=> sync_locked)
		else $error("lock not raised after enough sync groups");

	lock_loss_a: assert property (
		s_q.st == ST_SYNC && cfg.auto_sync && !rx_digital_reset && take && rx_in.code_err
		&& (s_q.err_cnt + 7'h01 >= cfg.err_limit) |=> !sync_locked)
		else $error("lock not dropped at error limit");

	lock_stays_a: assert property (
		$fell(sync_locked) |-> $past(rx_digital_reset) || $past(!cfg.auto_sync)
		|| $past(take && rx_in.code_err))
		else $error("lock dropped without an error group");

	relock_path_a: assert property (
		$rose(sync_locked) |-> $past(s_q.st) == ST_ACQ && $past(take && match))
		else $error("lock rose without a sync group");

	err_below_limit_a: assert property (
		sync_locked |-> s_q.err_cnt < cfg.err_limit)
		else $error("error count passed limit while locked");

	err_decrement_a: assert property (
		s_q.st == ST_SYNC && cfg.auto_sync && !rx_digital_reset && take && !rx_in.code_err
		&& (s_q.good_cnt + 9'h001 >= cfg.good_run) && s_q.err_cnt != '0
		|=> s_q.err_cnt == $past(s_q.err_cnt) - 7'h01)
		else $error("error count not lowered after good run");

	reset_clears_a: assert property (
		rx_digital_reset |=> !sync_locked && s_q.acq_cnt == '0 && s_q.err_cnt == '0)
		else $error("digital reset did not clear aligner");

	half_rate_a: assert property (
		cfg.byte_deser && push |=> !s_q.pair_phase)
		else $error("buffer written on the wrong half cycle");

	// lock level must agree with the state at every edge
	idle_unlocked_a: assert property (
		s_q.st == ST_IDLE |-> !sync_locked)
		else $error("lock high while idle");

	acq_unlocked_a: assert property (
		s_q.st == ST_ACQ |-> !sync_locked)
		else $error("lock high while acquiring");

	sync_holds_lock_a: assert property (
		s_q.st == ST_SYNC |-> sync_locked)
		else $error("lock low while in sync");

	err_clear_unlocked_a: assert property (
		s_q.st != ST_SYNC |-> s_q.err_cnt == '0)
		else $error("error count left over outside sync");

	good_reset_a: assert property (
		s_q.st == ST_SYNC && cfg.auto_sync && !rx_digital_reset && take && rx_in.code_err
		|=> s_q.good_cnt == '0)
		else $error("good run not restarted by error group");

	acq_hold_a: assert property (
		s_q.st == ST_ACQ && cfg.auto_sync && !rx_digital_reset && !take
		|=> s_q.acq_cnt == $past(s_q.acq_cnt))
		else $error("sync count moved without a word");

	reset_no_take_a: assert property (
		rx_digital_reset |-> !take)
		else $error("word taken during digital reset");

	phase_off_a: assert property (
		!cfg.byte_deser |=> !pcomp_wr_div2)
		else $error("pair phase toggled without byte deserialization");

	push_gated_a: assert property (
		push |-> take && fifo_in_ready)
		else $error("buffer written without a taken word");

	locked_c: cover property ($rose(sync_locked));
	lost_c: cover property ($fell(sync_locked) && !$past(rx_digital_reset));
	paired_c: cover property (cfg.byte_deser && push);

endmodule // rx_word_sync

// ==== test/link_partner.sv ====
// model of the remote transmitter feeding words and of the fabric draining pairs
// assumes the bench calls send and idle, and sets stall and slow by reference
`timescale 1ns/100ps
module link_partner
	import rx_sync_pkg::*;
(
	input  wire logic              clk,
	input  wire logic              rx_word_ready,
	input  wire logic              out_valid,
	input  wire logic [PAIR_W-1:0] out_data,
	output rx_word_t               rx_in,
	output logic                   rx_word_valid,
	output logic                   out_ready
);
	logic              stall;
	logic              slow;
	logic [PAIR_W-1:0] got[$];

	initial begin
		stall = 1'b0;
		slow = 1'b0;
		rx_in = '0;
		rx_word_valid = 1'b0;
		out_ready = 1'b1;
	end

	// word held until the edge that samples ready high
	task automatic send(input logic [WORD_W-1:0] w, input logic e);
		int n;
		n = 0;
		@(negedge clk);
		rx_word_valid = 1'b1;
		rx_in = '{word: w, code_err: e};
		do begin
			@(posedge clk);
			n++;
		end while (rx_word_ready !== 1'b1 && n < 50);
	endtask

	// released line must not look like the last word
	task automatic idle();
		@(negedge clk);
		rx_word_valid = 1'b0;
		rx_in.word = ~rx_in.word;
	endtask

	always @(negedge clk)
		out_ready <= !stall && (!slow || $urandom_range(1) == 1);

	always @(posedge clk)
		if (out_valid && out_ready)
			got.push_back(out_data);
endmodule // link_partner

// ==== test/tb_top.sv ====
// self-checking bench for rx_word_sync with a link partner model
// assumes one 200 MHz clock; stimulus changes on falling edges
`timescale 1ns/100ps
module tb_top
	import rx_sync_pkg::*;
();
	logic                 clk;
	logic                 resetn;
	logic                 rx_digital_reset;
	rx_cfg_t              cfg;
	rx_word_t             rx_in;
	logic                 rx_word_valid, rx_word_ready, sync_locked, rlv;
	logic                 pcomp_wr_div2, out_valid, out_ready, hit;
	logic [PAIR_W-1:0]    out_data;
	logic [WORD_W-1:0]    fill;
	logic [WORD_W-1:0]    w[2*FIFO_DEPTH];
	logic [ERR_W-1:0]     lims[3] = '{7'h01, 7'h03, 7'h40};
	logic                 rl_m[5] = '{1'b0, 1'b0, 1'b1, 1'b1, 1'b0};
	logic [RLV_SEL_W-1:0] rl_s[5] = '{5'h00, 5'h01, 5'h01, 5'h02, 5'h1F};
	logic [WORD_W-1:0]    rl_w[5] = '{10'h00F, 10'h00F, 10'h3FF, 10'h3FF, 10'h0FF};
	int                   fails = 0;
	int                   n_tests = 0;
	int                   cycles = 0;

	rx_word_sync i_rx_word_sync (.clk, .resetn, .rx_digital_reset, .cfg, .rx_word_valid, .rx_in,
		.rx_word_ready, .sync_locked, .rlv, .pcomp_wr_div2, .out_valid, .out_data, .out_ready);
	link_partner i_link_partner (.clk, .rx_word_ready, .out_valid, .out_data, .rx_in, .rx_word_valid,
		.out_ready);

	initial begin
		clk = 1'b0;
		forever #2.5 clk = ~clk;
	end

	// whole run needs well under this many cycles
	always @(posedge clk) begin
		cycles++;
		if (cycles == 5000) begin
			fails++;
			finish_test();
		end
	end

	task automatic chk_bit(input logic g, input logic e);
		n_tests++;
		if (g !== e) begin
			fails++;
			$display("Error t=%0t got=%h exp=%h", $time, g, e);
		end
	endtask

	task automatic chk_word(input logic [PAIR_W-1:0] g, input logic [PAIR_W-1:0] e);
		n_tests++;
		if (g !== e) begin
			fails++;
			$display("Error t=%0t got=%h exp=%h", $time, g, e);
		end
	endtask

	task automatic finish_test();
		$display("comparisons %0d mismatches %0d", n_tests, fails);
		if (fails == 0 && n_tests > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask

	task automatic wait_n(input int n);
		repeat (n) @(posedge clk);
		@(negedge clk);
	endtask

	function automatic int longest(input logic [WORD_W-1:0] v, input logic w10);
		int best, run;
		best = 1;
		run = 1;
		for (int i = 1; i < (w10 ? 10 : 8); i++) begin
			run = (v[i] == v[i-1]) ? run + 1 : 1;
			if (run > best)
				best = run;
		end
		return best;
	endfunction

	function automatic int thr(input logic w10, input logic [RLV_SEL_W-1:0] s);
		return (int'(s) + 1) * (w10 ? 5 : 4);
	endfunction

	function automatic logic [PAIR_W-1:0] pair_exp(input logic [WORD_W-1:0] a, input logic [WORD_W-1:0] b);
		return {b, a};
	endfunction

	// alternating polarity: a pattern-only matcher never locks
	task automatic acquire(input int n);
		for (int i = 0; i < n; i++) begin
			if (i == n - 1) begin
				i_link_partner.idle();
				wait_n(3);
				chk_bit(sync_locked, 1'b0);
			end
			i_link_partner.send(i[0] ? ~cfg.pattern : cfg.pattern, 1'b0);
		end
		i_link_partner.idle();
		wait_n(2);
		chk_bit(sync_locked, 1'b1);
	endtask

	task automatic errs(input int n);
		repeat (n) i_link_partner.send(10'h000, 1'b1);
		i_link_partner.idle();
		wait_n(2);
	endtask

	task automatic dig_reset();
		rx_digital_reset = 1'b1;
		wait_n(2);
		chk_bit(sync_locked, 1'b0);
		chk_bit(rlv, 1'b0);
		rx_digital_reset = 1'b0;
		wait_n(2);
	endtask

	initial begin
		resetn = 1'b0;
		rx_digital_reset = 1'b1;
		cfg = '0;
		cfg.pattern = 10'h17C;
		cfg.acq_needed = 8'h03;
		cfg.good_run = 9'h004;
		cfg.auto_sync = 1'b1;
		cfg.width_10 = 1'b1;
		void'($urandom(32'hD4DC));
		repeat (20) @(negedge clk);
		resetn = 1'b1;
		@(negedge clk);
		rx_digital_reset = 1'b0;
		wait_n(2);
		foreach (lims[k]) begin
			cfg.err_limit = lims[k];
			acquire(3);
			repeat (20) i_link_partner.send(10'($urandom()), 1'b0);
			errs(int'(lims[k]) - 1);
			chk_bit(sync_locked, 1'b1);
			errs(1);
			chk_bit(sync_locked, 1'b0);
			$display("lock and loss test done, limit %0d", lims[k]);
		end
		cfg.err_limit = 7'h02;
		for (int g = 1; g <= 2; g++) begin
			cfg.good_run = 9'(g);
			acquire(3);
			i_link_partner.send(10'h000, 1'b1);
			i_link_partner.send(10'h2AA, 1'b0);
			errs(1);
			chk_bit(sync_locked, 1'(g == 1));
			dig_reset();
			$display("good run test done, run %0d", g);
		end
		foreach (rl_w[k]) begin
			cfg.width_10 = rl_m[k];
			cfg.rlv_sel = rl_s[k];
			fill = rl_m[k] ? 10'h155 : 10'h055;
			repeat (3) i_link_partner.send(fill, 1'b0);
			i_link_partner.idle();
			wait_n(3);
			chk_bit(rlv, 1'b0);
			i_link_partner.send(rl_w[k], 1'b0);
			i_link_partner.idle();
			hit = longest(rl_w[k], rl_m[k]) >= thr(rl_m[k], rl_s[k]);
			// flag rose at the taking edge and stands for that edge and the next only
			chk_bit(rlv, hit);
			wait_n(1);
			chk_bit(rlv, hit);
		end
		$display("run length test done");
		cfg.width_10 = 1'b1;
		cfg.byte_deser = 1'b1;
		i_link_partner.stall = 1'b1;
		dig_reset();
		i_link_partner.got.delete();
		for (int i = 0; i < 2 * FIFO_DEPTH; i++) begin
			w[i] = 10'($urandom());
			i_link_partner.send(w[i], 1'b0);
			if (i == 0) begin
				i_link_partner.idle();
				wait_n(1);
				chk_bit(pcomp_wr_div2, 1'b1);
			end
		end
		i_link_partner.idle();
		wait_n(2);
		chk_bit(rx_word_ready, 1'b0);
		chk_bit(pcomp_wr_div2, 1'b0);
		i_link_partner.slow = 1'b1;
		i_link_partner.stall = 1'b0;
		for (int i = 0; i < 100 && i_link_partner.got.size() < FIFO_DEPTH; i++)
			wait_n(1);
		for (int i = 0; i < FIFO_DEPTH; i++)
			chk_word(i_link_partner.got[i], pair_exp(w[2*i], w[2*i+1]));
		chk_bit(out_valid, 1'b0);
		$display("pairing buffer test done");
		finish_test();
	end
endmodule // tb_top
